// >>> logic/scbd_pkg.sv
package scbd_pkg;
  // Opcode digit fields of the first instruction word
  localparam int H1_MSB = 15;
  localparam int H2_MSB = 11;
  localparam int H3_MSB = 7;
  localparam int H4_MSB = 3;
  // Group selectors in the second and third digits
  localparam logic [3:0] H2_DEC_BR = 4'h3;
  localparam logic [3:0] H2_FLT_LG = 4'h4;
  localparam logic [3:0] H2_FLT_EQ = 4'h5;
  localparam logic [3:0] H2_FLT_GT = 4'h6;
  localparam logic [3:0] H2_GENERIC = 4'h0;
  localparam logic [3:0] H3_COMMERCIAL = 4'h2;
  // Generic fourth digit codes
  localparam logic [3:0] GEN_HALT = 4'h0;
  localparam logic [3:0] GEN_CALL = 4'h1;
  localparam logic [3:0] GEN_BRK = 4'h2;
  localparam logic [3:0] GEN_RTT = 4'h3;
  localparam logic [3:0] GEN_CLK_ON = 4'h4;
  localparam logic [3:0] GEN_CLK_OFF = 4'h5;
  localparam logic [3:0] GEN_WDT_ON = 4'h6;
  localparam logic [3:0] GEN_WDT_OFF = 4'h7;
  localparam logic [3:0] GEN_VALID = 4'hB;
  localparam logic [3:0] GEN_DB_LOAD = 4'hC;
  localparam logic [3:0] GEN_DB_STORE = 4'hD;
  // Commercial fourth digit codes (second digit 0, third digit 2)
  localparam logic [3:0] COM_TRANSLATE = 4'h3;
  localparam logic [3:0] COM_MULTIPLY = 4'h9;
  localparam logic [3:0] COM_ADD = 4'hC;
  localparam logic [3:0] COM_SUBTRACT = 4'hD;
  localparam logic [3:0] COM_SHIFT = 4'hE;
  // Floating operand forms, first digit 8+r, second digit
  localparam logic [3:0] FOP_ZERO_TEST = 4'h8;
  localparam logic [3:0] FOP_NEG_TWO = 4'h9;
  localparam logic [3:0] FOP_ADD = 4'h9;
  localparam logic [3:0] FOP_SUB = 4'hC;
  localparam logic [3:0] FOP_MUL = 4'hC;
  localparam logic [3:0] FOP_DIV = 4'hC;
  localparam logic [3:0] FOP_NEG_FOUR = 4'hC;
  localparam logic [3:0] FOP_SWAP = 4'hD;
  localparam int TRANSLATE_TABLE_BYTES = 256;
  // Accumulator width and sign position
  localparam int ACC_W = 64;
  localparam int ACC_SIGN = 63;
  typedef enum logic [3:0] {
    SCBD_OP_NONE, SCBD_OP_ADD, SCBD_OP_SUB, SCBD_OP_MUL, SCBD_OP_DIV,
    SCBD_OP_LOAD, SCBD_OP_STORE, SCBD_OP_SWAP, SCBD_OP_CMP,
    SCBD_OP_CMPZ2, SCBD_OP_CMPZ4, SCBD_OP_NEG2, SCBD_OP_NEG4
  } scbd_fop_t;
  typedef enum logic [2:0] {
    SCBD_DOP_NONE, SCBD_DOP_ADD, SCBD_DOP_SUB, SCBD_DOP_MUL,
    SCBD_DOP_SHIFT, SCBD_DOP_TRANSLATE
  } scbd_dop_t;
endpackage

// >>> logic/scbd_decode.sv
`timescale 1ns/1ps
`default_nettype none
//
// Function
// - Branch on underflow, precision or significance flag set; complements on clear.
// - Float compare and zero tests produce greater and less flags.
// - Float negate flips only the sign bit of the operand.
// - Float arithmetic writes the accumulator; load, store, swap move data.
// - Decimal branches test greater and less flags with six senses.
// - Branch on overflow, truncation or sign-fault flag; complements on clear.
// - Wait stalls until decimal unit idle; wait-jump then branches always.
// - Decimal add, subtract, multiply write result to second descriptor.
// - Left and right shift forms decode as the one shift opcode.
// - Shift direction word bit 0: zero left, one right.
// - Translate move uses 256-byte table from the third descriptor.
// - Generic opcodes decoded from fourth digit with leading zeros.
// - Indicator branches: first digit zero, third digit high bit complements.
// - Decimal branches: second digit 3, first digit 1..7 selects pair.
// - Float branches: second digit 4..6, first digit register or 4; first digit 5..7 only with second digit 4.
module scbd_decode (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Instruction word in
  input wire logic instr_valid,
  input wire logic [15:0] instr_word,
  // Condition sources
  input wire logic float_greater_flag,
  input wire logic float_less_flag,
  input wire logic exponent_underflow_flag,
  input wire logic precision_error_flag,
  input wire logic significance_loss_flag,
  input wire logic [scbd_pkg::ACC_W-1:0] float_accumulator,
  input wire logic dec_greater_flag,
  input wire logic dec_less_flag,
  input wire logic result_too_large_flag,
  input wire logic cut_short_flag,
  input wire logic sign_fault_flag,
  input wire logic decimal_unit_busy,
  // Second shift control word sent with the decimal shift
  input wire logic [15:0] shift_control_two,
  // Float compare data path
  input wire logic [scbd_pkg::ACC_W-1:0] float_memory_operand,
  // Decoded outputs
  output logic branch_take,
  output logic stall,
  output logic [15:0] generic_onehot,
  output logic [3:0] float_op,
  output logic [1:0] float_acc_sel,
  output logic [2:0] decimal_op,
  output logic shift_direction_word,
  output logic [8:0] translate_table_bytes,
  output logic cmp_greater,
  output logic cmp_less,
  output logic [scbd_pkg::ACC_W-1:0] negated_operand
);
  // ------------------------------------------------------------
  // Field split
  // ------------------------------------------------------------
  wire logic [3:0] h1 = instr_word[15:12];
  wire logic [3:0] h2 = instr_word[11:8];
  wire logic [3:0] h3 = instr_word[7:4];
  wire logic [3:0] h4 = instr_word[3:0];
  wire logic cpl = h3[3];

  function automatic logic pick(input logic sense, input logic cond);
    pick = cpl_xor(sense, cond);
  endfunction
  function automatic logic cpl_xor(input logic s, input logic c);
    cpl_xor = s ? ~c : c;
  endfunction

  // ------------------------------------------------------------
  // Condition evaluation
  // ------------------------------------------------------------
  wire logic acc_sign = float_accumulator[scbd_pkg::ACC_SIGN];
  wire logic acc_frac_zero =
    (float_accumulator[scbd_pkg::ACC_SIGN-1:0] == '0);
  wire logic acc_neg = acc_sign & ~acc_frac_zero;
  wire logic acc_pos = ~acc_sign & ~acc_frac_zero;
  wire logic f_neq = float_greater_flag | float_less_flag;
  wire logic d_neq = dec_greater_flag | dec_less_flag;

  // register forms need h1 of 1..3; h1 zero is an indicator branch
  wire logic f_reg = ~h1[3] & ~h1[2] & (h1[1:0] != 2'h0);
  wire logic f_ind = ~h1[3] & h1[2];
  wire logic f_grp = (h2 == scbd_pkg::H2_FLT_LG) |
                     (h2 == scbd_pkg::H2_FLT_EQ) |
                     (h2 == scbd_pkg::H2_FLT_GT);
  logic f_cond;
  always_comb begin
    f_cond = 1'b0;
    case (h2)
      scbd_pkg::H2_FLT_LG: begin
        case (h1[1:0])
          2'h0: f_cond = f_reg ? acc_neg : float_less_flag;
          2'h1: f_cond = precision_error_flag;
          2'h2: f_cond = significance_loss_flag;
          default: f_cond = exponent_underflow_flag;
        endcase
        if (f_reg) f_cond = acc_neg;
      end
      scbd_pkg::H2_FLT_EQ: f_cond = f_reg ? acc_frac_zero : ~f_neq;
      scbd_pkg::H2_FLT_GT: f_cond = f_reg ? acc_pos : float_greater_flag;
      default: f_cond = 1'b0;
    endcase
  end
  wire logic f_valid = f_grp & (f_reg | (f_ind &
    ((h2 == scbd_pkg::H2_FLT_LG) | (h1[1:0] == 2'h0))));

  wire logic d_grp = (h2 == scbd_pkg::H2_DEC_BR) & ~h1[3] &
                     (h1[2:0] != 3'h0);
  logic d_cond;
  always_comb begin
    d_cond = 1'b0;
    case (h1[2:0])
      3'h1: d_cond = result_too_large_flag;
      3'h2: d_cond = cut_short_flag;
      3'h3: d_cond = sign_fault_flag;
      3'h4: d_cond = cpl;
      3'h5: d_cond = d_neq;
      3'h6: d_cond = dec_greater_flag;
      3'h7: d_cond = dec_less_flag;
      default: d_cond = 1'b0;
    endcase
  end
  wire logic d_wait = d_grp & (h1[2:0] == 3'h4);
  // complement sense from third digit, except the wait pair
  wire logic d_take = d_wait ? d_cond : pick(cpl, d_cond);

  // ------------------------------------------------------------
  // Generic and commercial operation decode
  // ------------------------------------------------------------
  wire logic lead_zero = (h1 == 4'h0) & (h2 == scbd_pkg::H2_GENERIC);
  wire logic gen_hit = lead_zero & (h3 == 4'h0);
  wire logic com_hit = lead_zero & (h3 == scbd_pkg::H3_COMMERCIAL);
  logic [2:0] dop;
  always_comb begin
    dop = scbd_pkg::SCBD_DOP_NONE;
    if (com_hit) begin
      case (h4)
        scbd_pkg::COM_ADD: dop = scbd_pkg::SCBD_DOP_ADD;
        scbd_pkg::COM_SUBTRACT: dop = scbd_pkg::SCBD_DOP_SUB;
        scbd_pkg::COM_MULTIPLY: dop = scbd_pkg::SCBD_DOP_MUL;
        // both shift forms arrive as this opcode
        scbd_pkg::COM_SHIFT: dop = scbd_pkg::SCBD_DOP_SHIFT;
        scbd_pkg::COM_TRANSLATE: dop = scbd_pkg::SCBD_DOP_TRANSLATE;
        default: dop = scbd_pkg::SCBD_DOP_NONE;
      endcase
    end
  end

  // float operand forms, first digit 8+r
  wire logic fl_row = h1[3];
  logic [3:0] fop;
  always_comb begin
    fop = scbd_pkg::SCBD_OP_NONE;
    if (fl_row) begin
      case ({h2, cpl})
        {4'h8, 1'b1}: fop = (h1[2:0] == 3'h0) ? scbd_pkg::SCBD_OP_CMPZ2 :
                      (h1[2:0] == 3'h1) ? scbd_pkg::SCBD_OP_CMP :
                                          scbd_pkg::SCBD_OP_LOAD;
        {4'h9, 1'b1}: fop = (h1[2:0] == 3'h0) ? scbd_pkg::SCBD_OP_NEG2 :
                      (h1[2:0] == 3'h1) ? scbd_pkg::SCBD_OP_SUB :
                                          scbd_pkg::SCBD_OP_ADD;
        {4'hC, 1'b0}: fop = (h1[2:0] == 3'h0) ? scbd_pkg::SCBD_OP_NEG4 :
                      (h1[2:0] == 3'h1) ? scbd_pkg::SCBD_OP_MUL :
                                          scbd_pkg::SCBD_OP_DIV;
        {4'hD, 1'b0}: fop = (h1[2:0] == 3'h1) ? scbd_pkg::SCBD_OP_SWAP :
                                          scbd_pkg::SCBD_OP_STORE;
        {4'h8, 1'b0}: fop = (h1[2:0] == 3'h0) ? scbd_pkg::SCBD_OP_CMPZ4 :
                                          scbd_pkg::SCBD_OP_NONE;
        default: fop = scbd_pkg::SCBD_OP_NONE;
      endcase
    end
  end

  // compare, magnitude by sign then fraction
  wire logic [scbd_pkg::ACC_W-1:0] cmp_a = (fop == scbd_pkg::SCBD_OP_CMP) ?
    float_accumulator : float_memory_operand;
  wire logic [scbd_pkg::ACC_W-1:0] cmp_b = (fop == scbd_pkg::SCBD_OP_CMP) ?
    float_memory_operand : '0;
  wire logic a_neg = cmp_a[scbd_pkg::ACC_SIGN];
  wire logic b_neg = cmp_b[scbd_pkg::ACC_SIGN];
  wire logic [scbd_pkg::ACC_W-2:0] a_mag = cmp_a[scbd_pkg::ACC_W-2:0];
  wire logic [scbd_pkg::ACC_W-2:0] b_mag = cmp_b[scbd_pkg::ACC_W-2:0];
  wire logic a_z = (a_mag == '0);
  wire logic b_z = (b_mag == '0);
  wire logic mag_gt = a_mag > b_mag;
  wire logic mag_lt = a_mag < b_mag;
  wire logic gt_c = (a_z & b_z) ? 1'b0 :
    (a_neg != b_neg) ? ((~a_neg & ~a_z) | (b_neg & a_z)) :
    (a_neg ? mag_lt : mag_gt);
  wire logic lt_c = (a_z & b_z) ? 1'b0 : ~gt_c & (cmp_a != cmp_b) &
    ~((a_neg != b_neg) & a_z & b_z);
  wire logic is_cmp = (fop == scbd_pkg::SCBD_OP_CMP) |
    (fop == scbd_pkg::SCBD_OP_CMPZ2) | (fop == scbd_pkg::SCBD_OP_CMPZ4);
  wire logic is_neg = (fop == scbd_pkg::SCBD_OP_NEG2) |
    (fop == scbd_pkg::SCBD_OP_NEG4);

  // ------------------------------------------------------------
  // Output registers
  // ------------------------------------------------------------
  wire logic take_nxt = instr_valid &
    ((f_valid & pick(cpl, f_cond)) | (d_grp & d_take));
  // hold while the decimal unit is busy
  wire logic stall_nxt = instr_valid & d_wait & decimal_unit_busy;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      branch_take <= 1'b0;
      stall <= 1'b0;
      generic_onehot <= 16'h0000;
      float_op <= 4'h0;
      float_acc_sel <= 2'h0;
      decimal_op <= 3'h0;
      shift_direction_word <= 1'b0;
      translate_table_bytes <= 9'h000;
      cmp_greater <= 1'b0;
      cmp_less <= 1'b0;
      negated_operand <= '0;
    end else begin
      branch_take <= take_nxt & ~stall_nxt;
      stall <= stall_nxt;
      generic_onehot <= (instr_valid & gen_hit) ? (16'h0001 << h4) : 16'h0000;
      float_op <= instr_valid ? fop : 4'h0;
      float_acc_sel <= h1[1:0];
      decimal_op <= instr_valid ? dop : 3'h0;
      // direction bit 0 of the shift word, 1 means right
      shift_direction_word <= instr_valid & (dop == scbd_pkg::SCBD_DOP_SHIFT)
        & shift_control_two[0];
      translate_table_bytes <=
        (instr_valid & (dop == scbd_pkg::SCBD_DOP_TRANSLATE)) ?
        9'(scbd_pkg::TRANSLATE_TABLE_BYTES) : 9'h000;
      if (instr_valid & is_cmp) begin
        cmp_greater <= gt_c;
        cmp_less <= lt_c;
      end
      negated_operand <= (instr_valid & is_neg) ? (float_memory_operand ^
        {1'b1, {(scbd_pkg::ACC_W-1){1'b0}}}) : float_memory_operand;
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  acc_zero_a: assert property (@(posedge clk) disable iff (rst)
    (instr_valid && h1 == 4'h1 && h2 == 4'h5 && !cpl) |=>
      (branch_take == $past(acc_frac_zero)))
    else $error("accumulator zero branch wrong");
  dec_wait_a: assert property (@(posedge clk) disable iff (rst)
    (instr_valid && d_wait && decimal_unit_busy) |=> (stall && !branch_take))
    else $error("wait did not stall");
  float_less_a: assert property (@(posedge clk) disable iff (rst)
    (instr_valid && h1 == 4'h4 && h2 == 4'h4) |=>
      (branch_take == ($past(float_less_flag) ^ $past(cpl))))
    else $error("float less branch wrong");
  dec_fault_a: assert property (@(posedge clk) disable iff (rst)
    (instr_valid && h1 == 4'h3 && h2 == 4'h3) |=>
      (branch_take == ($past(sign_fault_flag) ^ $past(cpl))))
    else $error("sign fault branch wrong");
  gen_halt_a: assert property (@(posedge clk) disable iff (rst)
    (instr_valid && instr_word == 16'h0000) |=> (generic_onehot == 16'h0001))
    else $error("halt not decoded");
  neg_sign_a: assert property (@(posedge clk) disable iff (rst)
    (instr_valid && is_neg) |=>
      ((negated_operand[scbd_pkg::ACC_SIGN] !=
        $past(float_memory_operand[scbd_pkg::ACC_SIGN])) &&
       (negated_operand[scbd_pkg::ACC_W-2:0] ==
        $past(float_memory_operand[scbd_pkg::ACC_W-2:0]))))
    else $error("negate must flip only the sign");
  dec_eq_a: assert property (@(posedge clk) disable iff (rst)
    (instr_valid && h1 == 4'h5 && h2 == 4'h3) |=>
      (branch_take == ($past(d_neq) ^ $past(cpl))))
    else $error("decimal equal branch wrong");
  shift_op_a: assert property (@(posedge clk) disable iff (rst)
    (instr_valid && instr_word == 16'h002E) |=>
      (decimal_op == scbd_pkg::SCBD_DOP_SHIFT))
    else $error("shift not decoded");
  shift_dir_a: assert property (@(posedge clk) disable iff (rst)
    (instr_valid && instr_word == 16'h002E) |=>
      (shift_direction_word == $past(shift_control_two[0])))
    else $error("shift direction wrong");
  cmp_zero_a: assert property (@(posedge clk) disable iff (rst)
    (instr_valid && (fop == scbd_pkg::SCBD_OP_CMPZ2 ||
      fop == scbd_pkg::SCBD_OP_CMPZ4) &&
      float_memory_operand[scbd_pkg::ACC_W-2:0] == '0) |=>
      (!cmp_greater && !cmp_less))
    else $error("zero compare not equal");
  table_size_a: assert property (@(posedge clk) disable iff (rst)
    (instr_valid && instr_word == 16'h0023) |=>
      (translate_table_bytes == 9'(scbd_pkg::TRANSLATE_TABLE_BYTES)))
    else $error("translate table size wrong");
endmodule // scbd_decode
`default_nettype wire

// >>> test/sci_commercial_branch_decode_tb.sv
`timescale 1ns/1ps
`default_nettype none
module sci_commercial_branch_decode_tb;
  typedef struct packed {
    logic [15:0] w;
    logic [4:0] f;
    logic [4:0] d;
    logic [1:0] a;
    logic b;
  } scbd_row_t;
  logic clk;
  logic rst;
  logic instr_valid;
  logic [15:0] instr_word;
  logic float_greater_flag, float_less_flag, exponent_underflow_flag;
  logic precision_error_flag, significance_loss_flag;
  logic [63:0] float_accumulator, float_memory_operand;
  logic dec_greater_flag, dec_less_flag, result_too_large_flag;
  logic cut_short_flag, sign_fault_flag, decimal_unit_busy;
  logic [15:0] shift_control_two;
  logic branch_take, stall, shift_direction_word, cmp_greater, cmp_less;
  logic [15:0] generic_onehot;
  logic [3:0] float_op;
  logic [1:0] float_acc_sel;
  logic [2:0] decimal_op;
  logic [8:0] translate_table_bytes;
  logic [63:0] negated_operand;
  int error_cnt = 0;
  int checked = 0;
  int cycles = 0;
  // Zero, positive, negative zero, negative
  logic [63:0] acc_tab [4] = '{64'h0, 64'h1, 64'h8000_0000_0000_0000,
    64'h8000_0000_0000_0001};
  // Flag order: f = greater, less, underflow, precision, significance;
  // d = greater, less, overflow, truncation, sign fault
  scbd_row_t rows [46] = '{
    '{16'h4400,5'h08,5'h0,2'd0,1'b1}, '{16'h4400,5'h10,5'h0,2'd0,1'b0},
    '{16'h4480,5'h00,5'h0,2'd0,1'b1}, '{16'h4480,5'h08,5'h0,2'd0,1'b0},
    '{16'h4600,5'h10,5'h0,2'd0,1'b1}, '{16'h4600,5'h08,5'h0,2'd0,1'b0},
    '{16'h4680,5'h10,5'h0,2'd0,1'b0}, '{16'h4680,5'h00,5'h0,2'd0,1'b1},
    '{16'h4500,5'h00,5'h0,2'd0,1'b1}, '{16'h4500,5'h10,5'h0,2'd0,1'b0},
    '{16'h4580,5'h08,5'h0,2'd0,1'b1}, '{16'h4580,5'h00,5'h0,2'd0,1'b0},
    '{16'h5400,5'h02,5'h0,2'd0,1'b1}, '{16'h5480,5'h02,5'h0,2'd0,1'b0},
    '{16'h5480,5'h00,5'h0,2'd0,1'b1}, '{16'h6400,5'h01,5'h0,2'd0,1'b1},
    '{16'h6400,5'h00,5'h0,2'd0,1'b0}, '{16'h6480,5'h00,5'h0,2'd0,1'b1},
    '{16'h7400,5'h04,5'h0,2'd0,1'b1}, '{16'h7480,5'h04,5'h0,2'd0,1'b0},
    '{16'h1500,5'h00,5'h0,2'd2,1'b1}, '{16'h1500,5'h00,5'h0,2'd1,1'b0},
    '{16'h1580,5'h00,5'h0,2'd1,1'b1}, '{16'h1580,5'h00,5'h0,2'd2,1'b0},
    '{16'h1600,5'h00,5'h0,2'd1,1'b1}, '{16'h1600,5'h00,5'h0,2'd2,1'b0},
    '{16'h1680,5'h00,5'h0,2'd2,1'b1}, '{16'h1680,5'h00,5'h0,2'd1,1'b0},
    '{16'h1400,5'h00,5'h0,2'd3,1'b1}, '{16'h1400,5'h00,5'h0,2'd2,1'b0},
    '{16'h1480,5'h00,5'h0,2'd2,1'b1}, '{16'h1480,5'h00,5'h0,2'd3,1'b0},
    '{16'h1300,5'h00,5'h04,2'd0,1'b1}, '{16'h1380,5'h00,5'h04,2'd0,1'b0},
    '{16'h2300,5'h00,5'h02,2'd0,1'b1}, '{16'h2380,5'h00,5'h00,2'd0,1'b1},
    '{16'h3300,5'h00,5'h01,2'd0,1'b1}, '{16'h3380,5'h00,5'h01,2'd0,1'b0},
    '{16'h5300,5'h00,5'h08,2'd0,1'b1}, '{16'h5380,5'h00,5'h00,2'd0,1'b1},
    '{16'h5380,5'h00,5'h10,2'd0,1'b0}, '{16'h6300,5'h00,5'h10,2'd0,1'b1},
    '{16'h6380,5'h00,5'h10,2'd0,1'b0}, '{16'h7300,5'h00,5'h08,2'd0,1'b1},
    '{16'h7380,5'h00,5'h08,2'd0,1'b0}, '{16'h7380,5'h00,5'h00,2'd0,1'b1}};
  logic [3:0] gen_codes [11] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6,
    4'h7, 4'hB, 4'hC, 4'hD};
  logic [15:0] dec_words [5] = '{16'h002C, 16'h002D, 16'h0029, 16'h002E,
    16'h0023};
  scbd_pkg::scbd_dop_t dec_ops [5] = '{scbd_pkg::SCBD_DOP_ADD,
    scbd_pkg::SCBD_DOP_SUB, scbd_pkg::SCBD_DOP_MUL, scbd_pkg::SCBD_DOP_SHIFT,
    scbd_pkg::SCBD_DOP_TRANSLATE};
  // Float operand forms: h1 8+r, r picks the accumulator
  logic [15:0] flt_words [7] = '{16'h9980, 16'hA980, 16'h9C00, 16'hAC00,
    16'hA880, 16'hAD00, 16'h9D00};
  scbd_pkg::scbd_fop_t flt_ops [7] = '{scbd_pkg::SCBD_OP_SUB,
    scbd_pkg::SCBD_OP_ADD, scbd_pkg::SCBD_OP_MUL, scbd_pkg::SCBD_OP_DIV,
    scbd_pkg::SCBD_OP_LOAD, scbd_pkg::SCBD_OP_STORE,
    scbd_pkg::SCBD_OP_SWAP};

  scbd_decode dut_u (.clk(clk), .rst(rst), .instr_valid(instr_valid),
    .instr_word(instr_word), .float_greater_flag(float_greater_flag),
    .float_less_flag(float_less_flag),
    .exponent_underflow_flag(exponent_underflow_flag),
    .precision_error_flag(precision_error_flag),
    .significance_loss_flag(significance_loss_flag),
    .float_accumulator(float_accumulator), .dec_greater_flag(dec_greater_flag),
    .dec_less_flag(dec_less_flag),
    .result_too_large_flag(result_too_large_flag),
    .cut_short_flag(cut_short_flag), .sign_fault_flag(sign_fault_flag),
    .decimal_unit_busy(decimal_unit_busy),
    .shift_control_two(shift_control_two),
    .float_memory_operand(float_memory_operand), .branch_take(branch_take),
    .stall(stall), .generic_onehot(generic_onehot), .float_op(float_op),
    .float_acc_sel(float_acc_sel), .decimal_op(decimal_op),
    .shift_direction_word(shift_direction_word),
    .translate_table_bytes(translate_table_bytes), .cmp_greater(cmp_greater),
    .cmp_less(cmp_less), .negated_operand(negated_operand));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic chk(input string what, input logic [63:0] seen,
                     input logic [63:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  // Registered answer: drive on one edge, sampled on the next, read after it
  task automatic apply(input logic v, input logic [15:0] w,
                       input logic [4:0] f, input logic [4:0] d,
                       input logic [63:0] a, input logic busy);
    @(posedge clk);
    instr_valid <= v;
    instr_word <= w;
    {float_greater_flag, float_less_flag, exponent_underflow_flag,
      precision_error_flag, significance_loss_flag} <= f;
    {dec_greater_flag, dec_less_flag, result_too_large_flag, cut_short_flag,
      sign_fault_flag} <= d;
    float_accumulator <= a;
    decimal_unit_busy <= busy;
    @(posedge clk);
    #1;
  endtask

  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Bounded run: a hang counts as a mismatch
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      chk("run_length", 64'(cycles), 64'h0);
      tally_and_finish();
    end
  end

  initial begin
    rst = 1'b1;
    instr_valid = 1'b0;
    instr_word = 16'h0;
    {float_greater_flag, float_less_flag, exponent_underflow_flag} = 3'h0;
    {precision_error_flag, significance_loss_flag} = 2'h0;
    {dec_greater_flag, dec_less_flag, result_too_large_flag} = 3'h0;
    {cut_short_flag, sign_fault_flag, decimal_unit_busy} = 3'h0;
    float_accumulator = 64'h0;
    float_memory_operand = 64'h0;
    shift_control_two = 16'h0000;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    // -----------------------------------------------------------
    // Branch condition table
    // -----------------------------------------------------------
    foreach (rows[i]) begin
      apply(1'b1, rows[i].w, rows[i].f, rows[i].d, acc_tab[rows[i].a], 1'b0);
      if (i < 20) begin
        chk("flt_take", 64'(branch_take), 64'(rows[i].b));
      end else if (i < 32) begin
        chk("acc_take", 64'(branch_take), 64'(rows[i].b));
      end else begin
        chk("dec_take", 64'(branch_take), 64'(rows[i].b));
      end
    end
    // -----------------------------------------------------------
    // Hand-written cases
    // -----------------------------------------------------------
    apply(1'b0, 16'h4400, 5'h08, 5'h0, 64'h0, 1'b0);
    chk("branch_take_idle", 64'(branch_take), 64'h0);
    // Indicator-group words must not reach these decoders
    apply(1'b1, 16'h0400, 5'h0, 5'h0, 64'h8000_0000_0000_0001, 1'b0);
    chk("indicator_flt", 64'(branch_take), 64'h0);
    apply(1'b1, 16'h0300, 5'h0, 5'h10, 64'h0, 1'b0);
    chk("indicator_dec", 64'(branch_take), 64'h0);
    apply(1'b1, 16'h5500, 5'h0, 5'h0, 64'h0, 1'b0);
    chk("flt_unused", 64'(branch_take), 64'h0);
    foreach (gen_codes[i]) begin
      apply(1'b1, {12'h000, gen_codes[i]}, 5'h0, 5'h0, 64'h0, 1'b0);
      chk("onehot", 64'(generic_onehot), 64'h1 << gen_codes[i]);
    end
    foreach (dec_words[i]) begin
      apply(1'b1, dec_words[i], 5'h0, 5'h0, 64'h0, 1'b0);
      chk("dec_op", 64'(decimal_op), 64'(dec_ops[i]));
      chk("table", 64'(translate_table_bytes), 64'(i == 4) << 8);
    end
    // Direction comes from bit 0 of the shift control word
    @(posedge clk);
    shift_control_two <= 16'h0001;
    apply(1'b1, 16'h002E, 5'h0, 5'h0, 64'h0, 1'b0);
    chk("shift_right", 64'(shift_direction_word), 64'h1);
    @(posedge clk);
    shift_control_two <= 16'h0000;
    apply(1'b1, 16'h002E, 5'h0, 5'h0, 64'h0, 1'b0);
    chk("shift_left", 64'(shift_direction_word), 64'h0);
    // Compare and negate against a negative memory operand
    @(posedge clk);
    float_memory_operand <= 64'h8000_0000_0000_0005;
    apply(1'b1, 16'h8880, 5'h0, 5'h0, 64'h0, 1'b0);
    chk("cmp_zero_two", 64'({cmp_greater, cmp_less}), 64'h1);
    apply(1'b1, 16'h9880, 5'h0, 5'h0, 64'h7, 1'b0);
    chk("cmp_acc", 64'({cmp_greater, cmp_less}), 64'h2);
    apply(1'b1, 16'h8980, 5'h0, 5'h0, 64'h0, 1'b0);
    chk("negate_two", negated_operand, 64'h5);
    apply(1'b1, 16'h8C00, 5'h0, 5'h0, 64'h0, 1'b0);
    chk("negate_four", negated_operand, 64'h5);
    // Negative zero still compares equal to zero
    @(posedge clk);
    float_memory_operand <= 64'h8000_0000_0000_0000;
    apply(1'b1, 16'h8800, 5'h0, 5'h0, 64'h0, 1'b0);
    chk("cmp_zero_four", 64'({cmp_greater, cmp_less}), 64'h0);
    foreach (flt_words[i]) begin
      apply(1'b1, flt_words[i], 5'h0, 5'h0, 64'h0, 1'b0);
      chk("float_op", 64'(float_op), 64'(flt_ops[i]));
      chk("acc_sel", 64'(float_acc_sel), 64'(flt_words[i][13:12]));
    end
    apply(1'b1, 16'h4300, 5'h0, 5'h0, 64'h0, 1'b1);
    chk("stall_wait", 64'({stall, branch_take}), 64'h2);
    apply(1'b1, 16'h4380, 5'h0, 5'h0, 64'h0, 1'b1);
    chk("stall_wait_jump", 64'({stall, branch_take}), 64'h2);
    apply(1'b1, 16'h4380, 5'h0, 5'h0, 64'h0, 1'b0);
    chk("wait_jump_free", 64'({stall, branch_take}), 64'h1);
    apply(1'b1, 16'h4300, 5'h0, 5'h0, 64'h0, 1'b0);
    chk("wait_free", 64'({stall, branch_take}), 64'h0);
    // Reset in mid-run clears a pending answer at once; the word is
    // dropped so that no request meets the releasing edge
    apply(1'b1, 16'h4400, 5'h08, 5'h0, 64'h0, 1'b0);
    rst <= 1'b1;
    instr_valid <= 1'b0;
    #1;
    chk("reset_branch", 64'({stall, branch_take}), 64'h0);
    chk("reset_generic", 64'(generic_onehot), 64'h0);
    @(posedge clk);
    rst <= 1'b0;
    apply(1'b1, 16'h4400, 5'h08, 5'h0, 64'h0, 1'b0);
    chk("resume_branch", 64'(branch_take), 64'h1);
    tally_and_finish();
  end
endmodule // sci_commercial_branch_decode_tb
`default_nettype wire
